// file: logic/hrp_pkg.sv
// package of shared constants for the host read-back port
// assumes both ends and the bus interface compile after it
package hrp_pkg;

	// ****************************************
	// host-visible locations
	// ****************************************
	localparam logic [2:0] SRC_SEL_ADDR    = 3'h5;
	localparam logic [2:0] AGC_SAMPLE_ADDR = 3'h2;
	localparam logic [2:0] STATUS_ADDR     = 3'h7;
	localparam logic [2:0] BYTE0_ADDR      = 3'h0;
	localparam logic [2:0] BYTE1_ADDR      = 3'h1;
	localparam logic [2:0] BYTE2_ADDR      = 3'h2;
	localparam logic [2:0] BYTE3_ADDR      = 3'h3;
	localparam logic [2:0] SRC_SEL_RESET   = 3'h0;

	// ****************************************
	// read-source codes
	// ****************************************
	localparam logic [2:0] SRC_IQ     = 3'h0;
	localparam logic [2:0] SRC_POLAR  = 3'h1;
	localparam logic [2:0] SRC_FREQ   = 3'h2;
	localparam logic [2:0] SRC_LEVEL  = 3'h4;
	localparam logic [2:0] SRC_AGC_TE = 3'h5;

	// ****************************************
	// status byte fields
	// ****************************************
	localparam int ST_DONE_BIT  = 0;
	localparam int ST_THR_BIT   = 1;
	localparam int ST_FULL_BIT  = 2;
	localparam int ST_EMPTY_BIT = 3;
	localparam int ST_DEPTH_LSB = 4;
	localparam int ST_DEPTH_W   = 3;

	// ****************************************
	// host strobe timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 8;
	localparam int SETUP_NS      = 16;
	localparam int STROBE_NS     = 120;
	localparam int HOLD_NS       = 16;
	localparam int GAP_NS        = 16;
	localparam int SETUP_CYC     = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_CYC    = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_CYC      = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int GAP_CYC       = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : hrp_pkg

// file: logic/hrp_bus_if.sv
// parallel host bus joining the host end and the device end
// assumes the testbench instantiates it and feeds both ends
`timescale 1ns/1ps
interface hrp_bus_if;
	logic [2:0] addr;
	logic       rd_n;
	logic       wr_n;
	logic [7:0] host_data_o;
	logic       host_data_oe_n;
	logic [7:0] dev_data_o;
	logic       dev_data_oe_n;
	logic [7:0] data_level;

	// shared data wire, pulled high when nobody drives
	assign data_level = !dev_data_oe_n  ? dev_data_o  :
	                    !host_data_oe_n ? host_data_o : 8'hff;

	modport dev
	(
		input  addr, rd_n, wr_n, data_level,
		output dev_data_o, dev_data_oe_n
	);
	modport host
	(
		input  data_level,
		output addr, rd_n, wr_n, host_data_o, host_data_oe_n
	);
endinterface : hrp_bus_if

// file: logic/hrp_sync.sv
// three-stage input synchroniser with agreement filter
// assumes in_a is asynchronous to clk
`timescale 1ns/1ps
module hrp_sync
#(
	parameter int           W   = 1,
	parameter logic [W-1:0] RST = '0
)
(
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] in_a,
	output logic      [W-1:0] out
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] out_d;

	// a change counts only once stages two and three agree
	always_comb
	begin
		out_d = (s2_q == s3_q) ? s3_q : out;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1_q <= RST;
			s2_q <= RST;
			s3_q <= RST;
			out  <= RST;
		end
		else
		begin
			s1_q <= in_a;
			s2_q <= s1_q;
			s3_q <= s2_q;
			out  <= out_d;
		end
	end
endmodule : hrp_sync

// file: logic/hrp_device.sv
// device end of the host read-back port
// assumes data words are stable while the host reads them;
// status and strobes arrive asynchronously and are synchronised here
`timescale 1ns/1ps
module hrp_device
#(
	parameter int DW = 16,
	parameter int LW = 24
)
(
	input  wire logic          CORE_CLK,
	input  wire logic          RSTN,
	hrp_bus_if.dev             BUS,
	input  wire logic [DW-1:0] I_VALUE,
	input  wire logic [DW-1:0] Q_VALUE,
	input  wire logic [DW-1:0] MAGNITUDE_VALUE,
	input  wire logic [DW-1:0] PHASE_VALUE,
	input  wire logic [DW-1:0] FREQ_VALUE,
	input  wire logic [LW-1:0] LEVEL_VALUE,
	input  wire logic [10:0]   AGC_MANTISSA,
	input  wire logic [3:0]    AGC_SHIFT,
	input  wire logic [DW-1:0] TIMING_ERROR,
	input  wire logic [2:0]    FIFO_DEPTH,
	input  wire logic          FIFO_EMPTY,
	input  wire logic          FIFO_FULL,
	input  wire logic          THRESHOLD_REACHED_N,
	input  wire logic          LEVEL_DONE_A,
	output logic [2:0]         READ_SOURCE,
	output logic               AGC_SAMPLE,
	output logic               FIFO_POP,
	output logic               PUSH_ALLOWED
);

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [1:0]  strobe_s;
	logic [10:0] addr_data_s;
	logic [6:0]  status_s;
	logic        rd_n_s;
	logic        wr_n_s;
	logic [2:0]  addr_s;
	logic [7:0]  data_s;

	hrp_sync #(.W(2), .RST(2'h3)) u_sync_strobe
	(
		.clk   (CORE_CLK),
		.rst_n (RSTN),
		.in_a  ({BUS.rd_n, BUS.wr_n}),
		.out   (strobe_s)
	);

	hrp_sync #(.W(11), .RST(11'h000)) u_sync_addr_data
	(
		.clk   (CORE_CLK),
		.rst_n (RSTN),
		.in_a  ({BUS.addr, BUS.data_level}),
		.out   (addr_data_s)
	);

	// threshold flag is active low, so it resets high
	hrp_sync #(.W(7), .RST(7'h02)) u_sync_status
	(
		.clk   (CORE_CLK),
		.rst_n (RSTN),
		.in_a  ({FIFO_DEPTH, FIFO_EMPTY, FIFO_FULL, THRESHOLD_REACHED_N, LEVEL_DONE_A}),
		.out   (status_s)
	);

	assign rd_n_s = strobe_s[1];
	assign wr_n_s = strobe_s[0];
	assign addr_s = addr_data_s[10:8];
	assign data_s = addr_data_s[7:0];

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [7:0] pick_byte(input logic [31:0] w, input logic [2:0] a);
		logic [7:0] b;
		case (a)
			hrp_pkg::BYTE0_ADDR: b = w[7:0];
			hrp_pkg::BYTE1_ADDR: b = w[15:8];
			hrp_pkg::BYTE2_ADDR: b = w[23:16];
			hrp_pkg::BYTE3_ADDR: b = w[31:24];
			default:             b = 8'h00;
		endcase
		return b;
	endfunction : pick_byte

	// ****************************************
	// state
	// ****************************************
	logic       rd_n_prev_q;
	logic       rd_n_prev_d;
	logic       wr_n_prev_q;
	logic       wr_n_prev_d;
	logic [2:0] src_q;
	logic [2:0] src_d;
	logic [14:0] agc_q;
	logic [14:0] agc_d;
	logic [7:0] dout_q;
	logic [7:0] dout_d;
	logic       oe_n_q;
	logic       oe_n_d;
	logic       agc_pulse_q;
	logic       agc_pulse_d;
	logic       pop_q;
	logic       pop_d;
	logic       rd_fall;
	logic       wr_rise;
	logic [7:0] status_byte;
	logic [7:0] read_byte;
	logic [31:0] src_word;
	logic [23:0] level_w;

	assign rd_fall = rd_n_prev_q & ~rd_n_s;
	assign wr_rise = ~wr_n_prev_q & wr_n_s;
	assign level_w = 24'(LEVEL_VALUE);

	// ****************************************
	// status byte
	// ****************************************
	always_comb
	begin
		status_byte = 8'h00;
		status_byte[hrp_pkg::ST_DEPTH_LSB +: hrp_pkg::ST_DEPTH_W] = status_s[6:4];
		status_byte[hrp_pkg::ST_EMPTY_BIT] = status_s[3];
		status_byte[hrp_pkg::ST_FULL_BIT] = status_s[2];
		status_byte[hrp_pkg::ST_THR_BIT] = status_s[1];
		status_byte[hrp_pkg::ST_DONE_BIT] = status_s[0];
	end

	// ****************************************
	// read multiplexer
	// ****************************************
	always_comb
	begin
		src_word = 32'h0000_0000;
		case (src_q)
			hrp_pkg::SRC_IQ:     src_word = {16'(Q_VALUE), 16'(I_VALUE)};
			hrp_pkg::SRC_POLAR:  src_word = {16'(PHASE_VALUE), 16'(MAGNITUDE_VALUE)};
			hrp_pkg::SRC_FREQ:   src_word = {16'h0000, 16'(FREQ_VALUE)};
			hrp_pkg::SRC_LEVEL:  src_word = {8'h00, level_w};
			// sampled mantissa, then shift and top mantissa
			hrp_pkg::SRC_AGC_TE: src_word = {16'(TIMING_ERROR), 1'b0, agc_q};
			default:             src_word = 32'h0000_0000;
		endcase
		read_byte = pick_byte(src_word, addr_s);
		if (addr_s == hrp_pkg::STATUS_ADDR)
			read_byte = status_byte;
	end

	// ****************************************
	// strobe handling
	// ****************************************
	always_comb
	begin
		rd_n_prev_d = rd_n_s;
		wr_n_prev_d = wr_n_s;
		src_d       = src_q;
		agc_d       = agc_q;
		dout_d      = dout_q;
		oe_n_d      = oe_n_q;
		agc_pulse_d = 1'b0;
		pop_d       = 1'b0;
		if (wr_rise)
		begin
			// only the low three data bits count
			if (addr_s == hrp_pkg::SRC_SEL_ADDR)
				src_d = data_s[2:0];
			// sampling keeps the two gain bytes coherent
			if (addr_s == hrp_pkg::AGC_SAMPLE_ADDR)
			begin
				agc_d       = {AGC_SHIFT, AGC_MANTISSA};
				agc_pulse_d = 1'b1;
			end
		end
		if (rd_fall)
		begin
			dout_d = read_byte;
			oe_n_d = 1'b0;
			// last byte of an IQ or polar sample pops unless empty
			if (addr_s == hrp_pkg::BYTE3_ADDR && !status_s[3]
			    && (src_q == hrp_pkg::SRC_IQ || src_q == hrp_pkg::SRC_POLAR))
				pop_d = 1'b1;
		end
		else if (rd_n_s)
			oe_n_d = 1'b1;
	end

	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			rd_n_prev_q <= 1'b1;
			wr_n_prev_q <= 1'b1;
			src_q       <= hrp_pkg::SRC_SEL_RESET;
			agc_q       <= 15'h0000;
			dout_q      <= 8'h00;
			oe_n_q      <= 1'b1;
			agc_pulse_q <= 1'b0;
			pop_q       <= 1'b0;
		end
		else
		begin
			rd_n_prev_q <= rd_n_prev_d;
			wr_n_prev_q <= wr_n_prev_d;
			src_q       <= src_d;
			agc_q       <= agc_d;
			dout_q      <= dout_d;
			oe_n_q      <= oe_n_d;
			agc_pulse_q <= agc_pulse_d;
			pop_q       <= pop_d;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign BUS.dev_data_o    = dout_q;
	assign BUS.dev_data_oe_n = oe_n_q;
	assign READ_SOURCE       = src_q;
	assign AGC_SAMPLE        = agc_pulse_q;
	assign FIFO_POP          = pop_q;
	assign PUSH_ALLOWED      = ~status_s[2];

endmodule : hrp_device

// file: logic/hrp_host.sv
// host end: turns single commands into strobed bus cycles
// assumes the device answers within the strobe low time
`timescale 1ns/1ps
module hrp_host
(
	input  wire logic       CORE_CLK,
	input  wire logic       RSTN,
	hrp_bus_if.host         BUS,
	input  wire logic       CMD_VALID,
	output logic            CMD_READY,
	input  wire logic       CMD_WRITE,
	input  wire logic [2:0] CMD_ADDR,
	input  wire logic [7:0] CMD_DATA,
	output logic            RSP_VALID,
	output logic [7:0]      RSP_DATA
);
	typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_GAP} hrp_state_t;

	hrp_state_t state_q;
	hrp_state_t state_d;
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	logic       wr_q;
	logic       wr_d;
	logic [2:0] addr_q;
	logic [2:0] addr_d;
	logic [7:0] data_q;
	logic [7:0] data_d;
	logic [7:0] rsp_q;
	logic [7:0] rsp_d;
	logic       rsp_v_q;
	logic       rsp_v_d;
	logic [7:0] din_s;

	hrp_sync #(.W(8), .RST(8'hff)) u_sync_data
	(
		.clk   (CORE_CLK),
		.rst_n (RSTN),
		.in_a  (BUS.data_level),
		.out   (din_s)
	);

	always_comb
	begin
		state_d = state_q;
		cnt_d   = cnt_q;
		wr_d    = wr_q;
		addr_d  = addr_q;
		data_d  = data_q;
		rsp_d   = rsp_q;
		rsp_v_d = 1'b0;
		case (state_q)
			ST_IDLE:
			begin
				if (CMD_VALID)
				begin
					wr_d    = CMD_WRITE;
					addr_d  = CMD_ADDR;
					data_d  = CMD_DATA;
					cnt_d   = 8'(hrp_pkg::SETUP_CYC);
					state_d = ST_SETUP;
				end
			end
			ST_SETUP:
			begin
				cnt_d = cnt_q - 8'h01;
				if (cnt_q == 8'h01)
				begin
					cnt_d   = 8'(hrp_pkg::STROBE_CYC);
					state_d = ST_STROBE;
				end
			end
			ST_STROBE:
			begin
				cnt_d = cnt_q - 8'h01;
				if (cnt_q == 8'h01)
				begin
					// write ends with the strobe rise
					// each read byte gets its own strobe
					if (!wr_q)
					begin
						rsp_d   = din_s;
						rsp_v_d = 1'b1;
					end
					cnt_d   = 8'(hrp_pkg::HOLD_CYC);
					state_d = ST_HOLD;
				end
			end
			ST_HOLD:
			begin
				cnt_d = cnt_q - 8'h01;
				if (cnt_q == 8'h01)
				begin
					cnt_d   = 8'(hrp_pkg::GAP_CYC);
					state_d = ST_GAP;
				end
			end
			ST_GAP:
			begin
				cnt_d = cnt_q - 8'h01;
				if (cnt_q == 8'h01)
					state_d = ST_IDLE;
			end
			default:
				state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			state_q <= ST_IDLE;
			cnt_q   <= 8'h00;
			wr_q    <= 1'b0;
			addr_q  <= 3'h0;
			data_q  <= 8'h00;
			rsp_q   <= 8'h00;
			rsp_v_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			wr_q    <= wr_d;
			addr_q  <= addr_d;
			data_q  <= data_d;
			rsp_q   <= rsp_d;
			rsp_v_q <= rsp_v_d;
		end
	end

	// data is driven from setup through hold so it is stable at the write rise
	assign CMD_READY          = (state_q == ST_IDLE);
	assign BUS.addr           = addr_q;
	assign BUS.host_data_o    = data_q;
	assign BUS.host_data_oe_n = ~(wr_q && (state_q == ST_SETUP || state_q == ST_STROBE
	                              || state_q == ST_HOLD));
	assign BUS.wr_n           = ~(wr_q && state_q == ST_STROBE);
	assign BUS.rd_n           = ~(!wr_q && state_q == ST_STROBE);
	assign RSP_VALID          = rsp_v_q;
	assign RSP_DATA           = rsp_q;
endmodule : hrp_host

// file: bench/hrp_bus_asserts.sv
// checker on the host bus between the two ends
// assumes it is hooked beside the bus interface in the bench
`timescale 1ns/1ps
module hrp_bus_asserts
(
	input wire logic       CORE_CLK,
	input wire logic       RSTN,
	input wire logic [2:0] addr,
	input wire logic       rd_n,
	input wire logic       wr_n,
	input wire logic [7:0] host_data_o,
	input wire logic       host_data_oe_n,
	input wire logic [7:0] dev_data_o,
	input wire logic       dev_data_oe_n,
	input wire logic [7:0] data_level
);
	// ****
	// read strobe width
	// ****
	logic [7:0] lo_q;
	logic [7:0] lo_d;
	always_comb
		lo_d = rd_n ? 8'h00 : lo_q + 8'h01;
	always_ff @(posedge CORE_CLK or negedge RSTN)
		if (!RSTN)
			lo_q <= 8'h00;
		else
			lo_q <= lo_d;
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!RSTN);
	// ****
	// properties
	// ****
	// drive on fall
	AST_RD_DRIVE: assert property ($fell(rd_n) |-> ##[3:7] !dev_data_oe_n)
		else $error("device did not drive after read fall");
	AST_RD_HOLD: assert property (!rd_n && !dev_data_oe_n |=> !dev_data_oe_n)
		else $error("device let go during read");
	AST_RD_RELEASE: assert property ($rose(rd_n) |-> ##[1:7] dev_data_oe_n)
		else $error("device kept driving after read");
	AST_IDLE_QUIET: assert property (rd_n [*8] |-> dev_data_oe_n)
		else $error("device drove with no read");
	AST_NO_CLASH: assert property (dev_data_oe_n || host_data_oe_n)
		else $error("both ends drive the data bus");
	AST_STATUS_B7: assert property (!rd_n && !dev_data_oe_n && addr == 3'h7 |-> !dev_data_o[7])
		else $error("status bit 7 not zero");
	AST_STROBE_LEN: assert property ($rose(rd_n) |-> lo_q == 8'(hrp_pkg::STROBE_CYC))
		else $error("read strobe width wrong");
	AST_ADDR_STABLE: assert property (!rd_n |-> $stable(addr))
		else $error("address moved during read");
	AST_WR_HOLD: assert property ($rose(wr_n) |-> (!host_data_oe_n && $stable(host_data_o) && $stable(addr)) [*2])
		else $error("write data not held after strobe");
	AST_RD_GAP: assert property ($rose(rd_n) |-> rd_n [*6])
		else $error("read strobe gap too short");
	cover property ($rose(wr_n) && addr == 3'h5);
	cover property ($fell(rd_n) && addr == 3'h7);
	cover property ($fell(rd_n) && addr == 3'h3);
endmodule : hrp_bus_asserts

// file: bench/tb_top.sv
// bench joining host end and device end over the bus interface
// assumes the shared package and both ends are compiled first
`timescale 1ns/1ps
module tb_top;
	logic        clk;
	logic        rst_n;
	logic [15:0] i_v, q_v, amp_v, ph_v, fr_v, te_v;
	logic [23:0] lvl_v;
	logic [10:0] mant, agc_m;
	logic [3:0]  shf, agc_s;
	logic [2:0]  depth, src, c_addr;
	logic        empty, full, thr_n, done, agc_p, pop, push_ok;
	logic        c_valid, c_ready, c_write, r_valid;
	logic [7:0]  c_data, r_data;
	logic [31:0] seed;
	int          bad_count, cmp_count, pop_cnt, agc_cnt, exp_pop;
	hrp_bus_if u_bus ();
	hrp_host u_hrp_host (.CORE_CLK(clk), .RSTN(rst_n), .BUS(u_bus.host),
		.CMD_VALID(c_valid), .CMD_READY(c_ready), .CMD_WRITE(c_write), .CMD_ADDR(c_addr),
		.CMD_DATA(c_data), .RSP_VALID(r_valid), .RSP_DATA(r_data));
	hrp_device u_hrp_device (.CORE_CLK(clk), .RSTN(rst_n), .BUS(u_bus.dev),
		.I_VALUE(i_v), .Q_VALUE(q_v), .MAGNITUDE_VALUE(amp_v), .PHASE_VALUE(ph_v),
		.FREQ_VALUE(fr_v), .LEVEL_VALUE(lvl_v), .AGC_MANTISSA(mant), .AGC_SHIFT(shf),
		.TIMING_ERROR(te_v), .FIFO_DEPTH(depth), .FIFO_EMPTY(empty), .FIFO_FULL(full),
		.THRESHOLD_REACHED_N(thr_n), .LEVEL_DONE_A(done), .READ_SOURCE(src),
		.AGC_SAMPLE(agc_p), .FIFO_POP(pop), .PUSH_ALLOWED(push_ok));
	hrp_bus_asserts u_hrp_bus_asserts (.CORE_CLK(clk), .RSTN(rst_n), .addr(u_bus.addr),
		.rd_n(u_bus.rd_n), .wr_n(u_bus.wr_n), .host_data_o(u_bus.host_data_o),
		.host_data_oe_n(u_bus.host_data_oe_n), .dev_data_o(u_bus.dev_data_o),
		.dev_data_oe_n(u_bus.dev_data_oe_n), .data_level(u_bus.data_level));
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// pulse counters, pulses stand one cycle
	always @(posedge clk)
	begin
		if (pop === 1'b1)
			pop_cnt++;
		if (agc_p === 1'b1)
			agc_cnt++;
	end
	// ****
	// helpers
	// ****
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		for (int k = 0; k < 32; k++)
			v = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
		return v;
	endfunction : lfsr
	task automatic roll();
		seed = lfsr(seed);
		{i_v, q_v} = seed;
		seed = lfsr(seed);
		{amp_v, ph_v} = seed;
		seed = lfsr(seed);
		{fr_v, te_v} = seed;
		seed = lfsr(seed);
		{lvl_v, depth, empty, full, thr_n, done} = seed[30:0];
		seed = lfsr(seed);
		{mant, shf} = seed[14:0];
	endtask : roll
	// expected byte; agc bytes come from the value sampled at the trigger write
	function automatic logic [7:0] model(input int s, input int a);
		logic [31:0] w;
		case (s)
			0: w = {q_v, i_v};
			1: w = {ph_v, amp_v};
			2: w = {16'h0000, fr_v};
			4: w = {8'h00, lvl_v};
			5: w = {te_v, 1'b0, agc_s, agc_m};
			default: w = 32'h0000_0000;
		endcase
		if (a == 7)
			return {1'b0, depth, empty, full, thr_n, done};
		if (a > 3)
			return 8'h00;
		return w[a*8 +: 8];
	endfunction : model
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_of_test
	task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check_byte
	// host side answers within a few tens of cycles; a longer wait is a hang
	task automatic give_up(input int n);
		if (n >= 100)
		begin
			bad_count++;
			end_of_test();
		end
	endtask : give_up
	task automatic cmd(input logic w, input logic [2:0] a, input logic [7:0] d);
		int n;
		n = 0;
		while (c_ready !== 1'b1 && n < 100)
		begin
			@(negedge clk);
			n++;
		end
		give_up(n);
		c_valid = 1'b1;
		c_write = w;
		c_addr = a;
		c_data = d;
		@(negedge clk);
		c_valid = 1'b0;
	endtask : cmd
	task automatic rd(input logic [2:0] a, input logic [7:0] exp);
		int n;
		cmd(1'b0, a, 8'h00);
		n = 0;
		while (r_valid !== 1'b1 && n < 100)
		begin
			@(negedge clk);
			n++;
		end
		give_up(n);
		check_byte(r_data, exp);
	endtask : rd
	// ****
	// main sequence
	// ****
	initial
	begin
		seed = 32'h409aecbd;
		{c_valid, c_write, c_addr, c_data} = 13'h0000;
		{agc_m, agc_s} = 15'h0000;
		roll();
		rst_n = 1'b0;
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		repeat (6) @(negedge clk);
		check_byte({5'h00, src}, 8'h00);
		for (int s = 0; s < 8; s++)
		begin
			roll();
			seed = lfsr(seed);
			cmd(1'b1, hrp_pkg::SRC_SEL_ADDR, {seed[7:3], s[2:0]});
			if (s == 5)
			begin
				cmd(1'b1, hrp_pkg::AGC_SAMPLE_ADDR, 8'h00);
				repeat (30) @(negedge clk);
				{agc_m, agc_s} = {mant, shf};
				{mant, shf} = ~{mant, shf};
				check_byte(8'(agc_cnt), 8'h01);
			end
			// the selection lands about 22 cycles after the host takes the write
			repeat (30) @(negedge clk);
			check_byte({5'h00, src}, 8'(s));
			check_byte({7'h00, push_ok}, {7'h00, !full});
			for (int a = 0; a < 8; a++)
			begin
				if (a == 3 && s < 2 && !empty)
					exp_pop++;
				rd(a[2:0], model(s, a));
			end
			repeat (4) @(negedge clk);
			check_byte(8'(pop_cnt), 8'(exp_pop));
			$display("source %0d test done", s);
		end
		cmd(1'b1, 3'h6, 8'h01);
		repeat (30) @(negedge clk);
		check_byte({5'h00, src}, 8'h07);
		$display("unmapped write test done");
		end_of_test();
	end
endmodule : tb_top
